// file: shared/msd_defs.svh
// address map, reset values and field positions of the memory space decoder
`ifndef MSD_DEFS_SVH
`define MSD_DEFS_SVH

// ==========================================================
// program memory
`define MSD_ROM_TOP        16'h1fff
`define MSD_VEC_LO         16'h0003
`define MSD_VEC_HI         16'h0093

// ==========================================================
// internal data memory
`define MSD_LOW_RAM_TOP    8'h7f
`define MSD_BIT_BASE       8'h20
`define MSD_SCRATCH_BASE   8'h30
`define MSD_SFR_BASE       8'h80
`define MSD_SP_ADDR        8'h81
`define MSD_PSW_ADDR       8'hd0

// ==========================================================
// reset values and fields
`define MSD_SP_RESET       8'h07
`define MSD_BANK_RESET     2'b00
`define MSD_BANK_LO_POS    3'd3
`define MSD_BANK_HI_POS    3'd4

`endif

// file: shared/msd_pkg.sv
// types shared by the memory space decoder and its bench
`default_nettype none

package msd_pkg;

    // ==========================================================
    // access modes of the internal data request
    typedef enum logic [2:0] {
        MSD_MODE_DIRECT   = 3'b000,
        MSD_MODE_INDIRECT = 3'b001,
        MSD_MODE_REGISTER = 3'b010,
        MSD_MODE_BIT      = 3'b011,
        MSD_MODE_PUSH     = 3'b100,
        MSD_MODE_POP      = 3'b101,
        MSD_MODE_EXT_DATA_POINTER_16 = 3'b110,
        MSD_MODE_EXT_REG  = 3'b111
    } msd_mode_t;

    typedef enum logic [1:0] {
        MSD_SRC_RAM = 2'b00,
        MSD_SRC_SFR = 2'b01,
        MSD_SRC_SP  = 2'b10
    } msd_src_t;

    typedef enum logic {
        MSD_ST_IDLE = 1'b0,
        MSD_ST_EXT  = 1'b1
    } msd_state_t;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic        valid;
        logic        write;
        msd_mode_t   mode;
        logic [7:0]  addr;
        logic [7:0]  wdata;
        logic [2:0]  reg_sel;
    } msd_req_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic        bit_op;
        logic [7:0]  addr;
        logic [2:0]  bit_pos;
        logic [7:0]  wdata;
    } msd_sfr_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } msd_ext_t;

    typedef struct packed {
        logic        valid;
        logic        external;
        logic        vector;
        logic [15:0] addr;
    } msd_fetch_t;

endpackage

`default_nettype wire

// file: core/msd_iram.sv
// 256-byte internal data ram with masked write and two asynchronous read ports
`default_nettype none

module msd_iram #(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 8
) (
    input  wire logic              i_clk,
    input  wire logic              i_we,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic [DATA_W-1:0] i_wmask,
    output logic      [DATA_W-1:0] o_rdata,
    input  wire logic [ADDR_W-1:0] i_ptr_addr,
    output logic      [DATA_W-1:0] o_ptr_rdata
);

    // contents are data, not control, so they carry no reset
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    assign o_rdata     = mem[i_addr];
    assign o_ptr_rdata = mem[i_ptr_addr];

    // masked write keeps byte and bit views of one location consistent
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_addr] <= (mem[i_addr] & ~i_wmask) | (i_wdata & i_wmask);
        end
    end

endmodule

`default_nettype wire

// file: core/msd_decoder.sv
// memory space decoder: program fetch steering, internal data, stack and external data
`include "msd_defs.svh"
`default_nettype none

module msd_decoder #(
    parameter logic [15:0] INT_ROM_TOP = `MSD_ROM_TOP
) (
    input  wire logic              i_clk,
    input  wire logic              i_reset_n,
    input  wire logic              i_external_fetch_select_pin,
    input  wire logic              i_fetch_valid,
    input  wire logic [15:0]       i_fetch_addr,
    output msd_pkg::msd_fetch_t    o_fetch_r,
    input  wire msd_pkg::msd_req_t i_req,
    output logic                   o_busy_r,
    output logic                   o_rvalid_r,
    output logic [7:0]             o_rdata_r,
    output logic                   o_rbit_r,
    output msd_pkg::msd_sfr_t      o_sfr_r,
    input  wire logic [7:0]        i_sfr_rdata,
    input  wire logic [15:0]       i_data_pointer_16,
    input  wire logic [7:0]        i_ext_page,
    output msd_pkg::msd_ext_t      o_ext_r,
    input  wire logic              i_ext_ack,
    input  wire logic [7:0]        i_ext_rdata,
    output logic                   o_ext_done_r,
    output logic [7:0]             o_ext_rdata_r,
    output logic [7:0]             o_stack_pointer_r,
    output logic [1:0]             o_active_bank_r
);
    import msd_pkg::*;

    // ==========================================================
    // helpers
    function automatic logic [7:0] bit_ram_byte(input logic [7:0] bit_addr);
        bit_ram_byte = `MSD_BIT_BASE + {4'h0, bit_addr[6:3]};
    endfunction

    function automatic logic [7:0] bit_sfr_byte(input logic [7:0] bit_addr);
        bit_sfr_byte = {bit_addr[7:3], 3'b000};
    endfunction

    // ==========================================================
    // state
    msd_state_t state_r;
    msd_state_t state_nxt;
    logic [7:0] sp_r;
    logic [7:0] sp_nxt;
    logic [1:0] bank_r;
    logic [1:0] bank_nxt;

    logic       p1_valid_r;
    msd_src_t   p1_src_r;
    logic [7:0] p1_ram_r;
    logic [7:0] p1_sp_r;
    logic [2:0] p1_pos_r;

    // ==========================================================
    // decode signals
    logic       take;
    logic       rd_req;
    logic [7:0] ram_addr;
    logic [7:0] ram_wdata;
    logic [7:0] ram_wmask;
    logic       ram_we;
    logic [7:0] ram_rdata;
    logic [7:0] ptr_addr;
    logic [7:0] ptr_data;
    logic       to_sfr;
    logic       sfr_bit;
    logic [7:0] sfr_addr;
    logic [2:0] bit_pos;
    msd_src_t   src;
    logic       ext_go;
    logic [15:0] ext_addr;
    logic [7:0] sel_data;

    assign take = i_req.valid && (state_r == MSD_ST_IDLE);

    // ==========================================================
    // internal ram
    msd_iram #(
        .ADDR_W (8),
        .DATA_W (8)
    ) u_iram (
        .i_clk       (i_clk),
        .i_we        (ram_we && take),
        .i_addr      (ram_addr),
        .i_wdata     (ram_wdata),
        .i_wmask     (ram_wmask),
        .o_rdata     (ram_rdata),
        .i_ptr_addr  (ptr_addr),
        .o_ptr_rdata (ptr_data)
    );

    // only the first two registers of the active bank can be pointers
    assign ptr_addr = {3'b000, bank_r, 2'b00, i_req.reg_sel[0]};

    // ==========================================================
    // address decode
    always_comb begin
        ram_addr  = i_req.addr;
        ram_wdata = i_req.wdata;
        ram_wmask = 8'hff;
        ram_we    = 1'b0;
        to_sfr    = 1'b0;
        sfr_bit   = 1'b0;
        sfr_addr  = i_req.addr;
        bit_pos   = 3'd0;
        src       = MSD_SRC_RAM;
        sp_nxt    = sp_r;
        bank_nxt  = bank_r;
        ext_go    = 1'b0;
        ext_addr  = 16'h0000;
        rd_req    = !i_req.write;
        case (i_req.mode)
            MSD_MODE_DIRECT: begin
                if (i_req.addr >= `MSD_SFR_BASE) begin
                    if (i_req.addr == `MSD_SP_ADDR) begin
                        src = MSD_SRC_SP;
                        if (i_req.write) begin
                            sp_nxt = i_req.wdata;
                        end
                    end else begin
                        to_sfr = 1'b1;
                        src    = MSD_SRC_SFR;
                        if (i_req.write && i_req.addr == `MSD_PSW_ADDR) begin
                            bank_nxt = {i_req.wdata[`MSD_BANK_HI_POS], i_req.wdata[`MSD_BANK_LO_POS]};
                        end
                    end
                end else begin
                    // lower ram incl. scratch 30H..7FH as plain bytes
                    ram_we = i_req.write;
                end
            end
            MSD_MODE_INDIRECT: begin
                // pointer value reaches all 256 bytes, never the register area
                ram_addr = ptr_data;
                ram_we   = i_req.write;
            end
            MSD_MODE_REGISTER: begin
                ram_addr = {3'b000, bank_r, i_req.reg_sel};
                ram_we   = i_req.write;
            end
            MSD_MODE_BIT: begin
                bit_pos = i_req.addr[2:0];
                if (i_req.addr >= `MSD_SFR_BASE) begin
                    to_sfr   = 1'b1;
                    sfr_bit  = 1'b1;
                    sfr_addr = bit_sfr_byte(i_req.addr);
                    src      = MSD_SRC_SFR;
                    if (i_req.write && sfr_addr == `MSD_PSW_ADDR) begin
                        if (bit_pos == `MSD_BANK_LO_POS) begin
                            bank_nxt[0] = i_req.wdata[0];
                        end
                        if (bit_pos == `MSD_BANK_HI_POS) begin
                            bank_nxt[1] = i_req.wdata[0];
                        end
                    end
                end else begin
                    ram_addr  = bit_ram_byte(i_req.addr);
                    ram_we    = i_req.write;
                    ram_wmask = 8'h01 << bit_pos;
                    ram_wdata = {8{i_req.wdata[0]}};
                end
            end
            MSD_MODE_PUSH: begin
                // increment first, then store at the new top
                sp_nxt   = sp_r + 8'h01;
                ram_addr = sp_nxt;
                ram_we   = 1'b1;
                rd_req   = 1'b0;
            end
            MSD_MODE_POP: begin
                ram_addr = sp_r;
                sp_nxt   = sp_r - 8'h01;
                rd_req   = 1'b1;
            end
            MSD_MODE_EXT_DATA_POINTER_16: begin
                ext_go   = 1'b1;
                ext_addr = i_data_pointer_16;
                rd_req   = 1'b0;
            end
            MSD_MODE_EXT_REG: begin
                ext_go   = 1'b1;
                ext_addr = {i_ext_page, ptr_data};
                rd_req   = 1'b0;
            end
            default: begin
                rd_req = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // program fetch steering
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_fetch_r <= '0;
        end else begin
            o_fetch_r.valid    <= i_fetch_valid;
            o_fetch_r.addr     <= i_fetch_addr;
            // above the internal top always external; pin low forces external
            o_fetch_r.external <= !i_external_fetch_select_pin || (i_fetch_addr > INT_ROM_TOP);
            o_fetch_r.vector   <= (i_fetch_addr >= `MSD_VEC_LO) && (i_fetch_addr <= `MSD_VEC_HI);
        end
    end

    // ==========================================================
    // stack pointer and bank select
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sp_r <= `MSD_SP_RESET;
        end else if (take) begin
            sp_r <= sp_nxt;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            bank_r <= `MSD_BANK_RESET;
        end else if (take) begin
            bank_r <= bank_nxt;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_stack_pointer_r <= `MSD_SP_RESET;
            o_active_bank_r   <= `MSD_BANK_RESET;
        end else begin
            o_stack_pointer_r <= (take) ? sp_nxt : sp_r;
            o_active_bank_r   <= (take) ? bank_nxt : bank_r;
        end
    end

    // ==========================================================
    // register area port: the sole path to peripherals
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_sfr_r <= '0;
        end else begin
            o_sfr_r.valid   <= take && to_sfr;
            o_sfr_r.write   <= i_req.write;
            o_sfr_r.bit_op  <= sfr_bit;
            o_sfr_r.addr    <= sfr_addr;
            o_sfr_r.bit_pos <= bit_pos;
            o_sfr_r.wdata   <= i_req.wdata;
        end
    end

    // ==========================================================
    // read pipeline: two edges for every internal read
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            p1_valid_r <= 1'b0;
            p1_src_r   <= MSD_SRC_RAM;
            p1_ram_r   <= 8'h00;
            p1_sp_r    <= 8'h00;
            p1_pos_r   <= 3'd0;
        end else begin
            p1_valid_r <= take && rd_req;
            p1_src_r   <= src;
            p1_ram_r   <= ram_rdata;
            p1_sp_r    <= sp_r;
            p1_pos_r   <= bit_pos;
        end
    end

    always_comb begin
        case (p1_src_r)
            MSD_SRC_SFR: sel_data = i_sfr_rdata;
            MSD_SRC_SP:  sel_data = p1_sp_r;
            default:     sel_data = p1_ram_r;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rvalid_r <= 1'b0;
            o_rdata_r  <= 8'h00;
            o_rbit_r   <= 1'b0;
        end else begin
            o_rvalid_r <= p1_valid_r;
            if (p1_valid_r) begin
                o_rdata_r <= sel_data;
                o_rbit_r  <= sel_data[p1_pos_r];
            end
        end
    end

    // ==========================================================
    // external data move: request held until acknowledged
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            MSD_ST_IDLE: begin
                if (take && ext_go) begin
                    state_nxt = MSD_ST_EXT;
                end
            end
            MSD_ST_EXT: begin
                if (i_ext_ack) begin
                    state_nxt = MSD_ST_IDLE;
                end
            end
            default: begin
                state_nxt = MSD_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_r <= MSD_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // busy mirrors the wait state; new requests are ignored meanwhile
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_busy_r <= 1'b0;
        end else begin
            o_busy_r <= (state_nxt == MSD_ST_EXT);
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_ext_r <= '0;
        end else if (take && ext_go) begin
            o_ext_r.valid <= 1'b1;
            o_ext_r.write <= i_req.write;
            o_ext_r.addr  <= ext_addr;
            o_ext_r.wdata <= i_req.wdata;
        end else if (state_r == MSD_ST_EXT && i_ext_ack) begin
            o_ext_r.valid <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_ext_done_r  <= 1'b0;
            o_ext_rdata_r <= 8'h00;
        end else begin
            o_ext_done_r <= (state_r == MSD_ST_EXT) && i_ext_ack;
            if ((state_r == MSD_ST_EXT) && i_ext_ack && !o_ext_r.write) begin
                o_ext_rdata_r <= i_ext_rdata;
            end
        end
    end

endmodule

`default_nettype wire

// file: sim/msd_chk.sv
// concurrent checks on the memory space decoder ports
`default_nettype none

module msd_chk #(
    parameter logic [15:0] INT_ROM_TOP = 16'h1fff
) (
    input  wire logic                i_clk,
    input  wire logic                i_reset_n,
    input  wire logic                i_external_fetch_select_pin,
    input  wire logic                i_fetch_valid,
    input  wire logic [15:0]         i_fetch_addr,
    input  wire msd_pkg::msd_fetch_t o_fetch_r,
    input  wire msd_pkg::msd_req_t   i_req,
    input  wire logic                o_busy_r,
    input  wire logic                o_rvalid_r,
    input  wire msd_pkg::msd_sfr_t   o_sfr_r,
    input  wire logic [15:0]         i_data_pointer_16,
    input  wire msd_pkg::msd_ext_t   o_ext_r,
    input  wire logic                i_ext_ack,
    input  wire logic                o_ext_done_r,
    input  wire logic [7:0]          o_stack_pointer_r,
    input  wire logic [1:0]          o_active_bank_r
);
    import msd_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    logic      tk;
    msd_mode_t md;
    // a request counts only on an edge where the decoder is free
    assign tk = i_req.valid && !o_busy_r;
    assign md = i_req.mode;

    // ==========================================================
    // fetch and internal data
    a_fetch_route: assert property (i_fetch_valid |=> o_fetch_r.valid &&
        o_fetch_r.external == (!$past(i_external_fetch_select_pin) || $past(i_fetch_addr) > INT_ROM_TOP))
        else $error("fetch route");
    a_fetch_addr: assert property (i_fetch_valid |=> o_fetch_r.addr == $past(i_fetch_addr) &&
        o_fetch_r.vector == ($past(i_fetch_addr) inside {[16'h0003:16'h0093]}))
        else $error("fetch addr");
    a_direct_low: assert property (tk && md == MSD_MODE_DIRECT && !i_req.addr[7] |=> !o_sfr_r.valid)
        else $error("low direct");
    a_indirect_upper: assert property (tk && md == MSD_MODE_INDIRECT |=> !o_sfr_r.valid)
        else $error("indirect");
    a_direct_sfr: assert property (tk && md == MSD_MODE_DIRECT && i_req.addr[7] && i_req.addr != 8'h81
        |=> o_sfr_r.valid && !o_sfr_r.bit_op && o_sfr_r.addr == $past(i_req.addr))
        else $error("direct sfr");
    a_sfr_bit: assert property (tk && md == MSD_MODE_BIT && i_req.addr[7] |=> o_sfr_r.valid &&
        o_sfr_r.bit_op && o_sfr_r.addr == {$past(i_req.addr[7:3]), 3'h0} && o_sfr_r.bit_pos == $past(i_req.addr[2:0]))
        else $error("sfr bit");
    a_read_answer: assert property (tk && !i_req.write && md inside {MSD_MODE_DIRECT, MSD_MODE_INDIRECT,
        MSD_MODE_REGISTER, MSD_MODE_BIT, MSD_MODE_POP} |-> ##2 o_rvalid_r)
        else $error("no read");
    a_bank_select: assert property (tk && i_req.write && md == MSD_MODE_DIRECT && i_req.addr == 8'hd0
        |=> o_active_bank_r == $past(i_req.wdata[4:3]))
        else $error("bank");

    // ==========================================================
    // stack and external data
    a_push_pre: assert property (tk && md == MSD_MODE_PUSH |=> o_stack_pointer_r == $past(o_stack_pointer_r) + 8'h01)
        else $error("push sp");
    a_pop_post: assert property (tk && md == MSD_MODE_POP |=> o_stack_pointer_r == $past(o_stack_pointer_r) - 8'h01)
        else $error("pop sp");
    a_ext_pointer: assert property (tk && md == MSD_MODE_EXT_DATA_POINTER_16 |=> o_ext_r.valid &&
        o_ext_r.addr == $past(i_data_pointer_16))
        else $error("ext addr");
    a_ext_hold: assert property (o_ext_r.valid && !i_ext_ack |=> o_ext_r.valid && $stable(o_ext_r))
        else $error("ext hold");
    a_ext_done: assert property (o_ext_r.valid && i_ext_ack |=> o_ext_done_r && !o_ext_r.valid)
        else $error("ext done");

    c_fetch_ext: cover property (o_fetch_r.valid && o_fetch_r.external);
    c_sfr_bit: cover property (o_sfr_r.valid && o_sfr_r.bit_op);
    c_ext_done: cover property (o_ext_done_r);
endmodule

bind msd_decoder msd_chk #(.INT_ROM_TOP(INT_ROM_TOP)) u_msd_chk (.*);

`default_nettype wire

// file: sim/msd_partner.sv
// register area and external data memory standing behind the decoder
`default_nettype none

module msd_partner (
    input  wire logic              i_clk,
    input  wire logic              i_reset_n,
    input  wire msd_pkg::msd_sfr_t i_sfr,
    output logic [7:0]             o_sfr_rdata,
    input  wire msd_pkg::msd_ext_t i_ext,
    output logic                   o_ext_ack,
    output logic [7:0]             o_ext_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import msd_pkg::*;
    logic [7:0] noise_r;
    logic [1:0] wait_r;
    // outside a register cycle the data lines wander so stale values never match
    assign o_sfr_rdata = i_sfr.valid ? (i_sfr.addr ^ 8'ha5) : noise_r;
    always @(negedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_ext_ack <= 1'b0;
            o_ext_rdata <= 8'h00;
            wait_r <= 2'h0;
            noise_r <= 8'h00;
        end else begin
            noise_r <= noise_r + 8'h3b;
            if (o_ext_ack) begin
                o_ext_ack <= 1'b0;
                o_ext_rdata <= ~o_ext_rdata;
                wait_r <= 2'($urandom_range(3));
            end else if (i_ext.valid) begin
                // random accept delay: prompt and slow answers both occur
                if (wait_r == 2'h0) begin
                    o_ext_ack <= 1'b1;
                    o_ext_rdata <= i_ext.addr[7:0] ^ i_ext.addr[15:8] ^ 8'h3c;
                end else begin
                    wait_r <= wait_r - 2'h1;
                end
            end
        end
    end
endmodule

`default_nettype wire

// file: sim/testbench.sv
// self-checking bench of the memory space decoder
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import msd_pkg::*;
    localparam logic [15:0] TBL [8] = '{16'h0000, 16'h0002, 16'h0003, 16'h0093,
                                        16'h0094, 16'h1fff, 16'h2000, 16'hffff};
    logic        i_clk = 1'b0;
    logic        i_reset_n = 1'b0;
    logic        pin = 1'b1;
    logic        fvalid = 1'b0;
    logic [15:0] faddr = '0;
    logic [15:0] data_pointer_16 = '0;
    logic [7:0]  page = '0;
    msd_req_t    req = '0;
    msd_fetch_t  fetch;
    msd_sfr_t    special_function_register;
    msd_ext_t    ext;
    logic        busy, rvalid, rbit, ack, done, ext_seen;
    logic [7:0]  rdata, sfr_rdata, ext_rdata, ext_rd, sp;
    logic [1:0]  bank;
    logic [8:0]  re;
    logic [16:0] xe;
    logic [17:0] fetch_q [$];
    logic [8:0]  read_q [$];
    logic [16:0] ext_q [$];
    int          bad_count = 0;
    int          check_count = 0;
    int          cycles = 0;

    always #2.5 i_clk = ~i_clk;

    msd_decoder u_msd_decoder (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_external_fetch_select_pin(pin), .i_fetch_valid(fvalid),
        .i_fetch_addr(faddr), .o_fetch_r(fetch), .i_req(req), .o_busy_r(busy), .o_rvalid_r(rvalid),
        .o_rdata_r(rdata), .o_rbit_r(rbit), .o_sfr_r(special_function_register), .i_sfr_rdata(sfr_rdata), .i_data_pointer_16(data_pointer_16),
        .i_ext_page(page), .o_ext_r(ext), .i_ext_ack(ack), .i_ext_rdata(ext_rdata), .o_ext_done_r(done),
        .o_ext_rdata_r(ext_rd), .o_stack_pointer_r(sp), .o_active_bank_r(bank));
    msd_partner u_msd_partner (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_sfr(special_function_register), .o_sfr_rdata(sfr_rdata),
        .i_ext(ext), .o_ext_ack(ack), .o_ext_rdata(ext_rdata));

    // ==========================================================
    // compares and bus tasks
    task automatic cmp_word(string n, logic [17:0] e, logic [17:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cmp_byte(string n, logic [7:0] e, logic [7:0] g);
        cmp_word(n, {10'h0, e}, {10'h0, g});
    endtask
    task automatic print_verdict();
        if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic issue(logic w, msd_mode_t m, logic [7:0] a, logic [7:0] d, logic [2:0] r = 3'h0);
        @(negedge i_clk);
        req <= '{1'b1, w, m, a, d, r};
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        issue(1'b1, MSD_MODE_DIRECT, a, d);
    endtask
    task automatic rd(msd_mode_t m, logic [7:0] a, logic [7:0] e, logic b = 1'b0);
        issue(1'b0, m, a, 8'h00);
        read_q.push_back({b, e});
    endtask
    task automatic idle();
        @(negedge i_clk);
        req <= '0;
    endtask
    task automatic exm(logic w, msd_mode_t m, logic [2:0] r, logic [15:0] a);
        int k;
        issue(w, m, 8'h00, 8'h5a, r);
        ext_q.push_back({w, a});
        // lands while busy, so it must leave ram untouched
        wr(8'h31, 8'hee);
        idle();
        for (k = 0; k < 20 && done !== 1'b1; k++) @(negedge i_clk);
    endtask

    // ==========================================================
    // result watcher
    always @(negedge i_clk) begin
        if (i_reset_n && fetch.valid === 1'b1)
            cmp_word("fetch", fetch_q.size() != 0 ? fetch_q.pop_front() : 'x, fetch[17:0]);
        if (i_reset_n && rvalid === 1'b1) begin
            re = read_q.size() != 0 ? read_q.pop_front() : 'x;
            if (re[8] === 1'b1) cmp_byte("bit", {7'h0, re[0]}, {7'h0, rbit});
            else cmp_byte("read byte", re[7:0], rdata);
        end
        if (ext.valid === 1'b1 && !ext_seen) begin
            ext_seen = 1'b1;
            cmp_word("ext addr", {2'h0, ext_q.size() != 0 ? ext_q[0][15:0] : 16'hxxxx}, {2'h0, ext.addr});
        end
        if (done === 1'b1) begin
            ext_seen = 1'b0;
            xe = ext_q.size() != 0 ? ext_q.pop_front() : 'x;
            if (xe[16] !== 1'b1) cmp_byte("ext data", xe[7:0] ^ xe[15:8] ^ 8'h3c, ext_rd);
        end
    end

    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 4000) begin
            bad_count++;
            print_verdict();
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        int k;
        logic [7:0] v, b;
        logic [15:0] a;
        logic p;
        ext_seen = 1'b0;
        void'($urandom(32'h89bb15ea));
        repeat (10) @(negedge i_clk);
        i_reset_n = 1'b1;
        cmp_byte("sp", 8'h07, sp);
        cmp_byte("bank", 8'h00, {6'h0, bank});
        for (k = 0; k < 48; k++) begin
            a = k < 16 ? TBL[k % 8] : 16'($urandom);
            p = k < 16 ? k[3] : 1'($urandom);
            @(negedge i_clk);
            fvalid <= 1'b1;
            faddr <= a;
            pin <= p;
            fetch_q.push_back({!p || a > 16'h1fff, a inside {[16'h0003:16'h0093]}, a});
        end
        @(negedge i_clk);
        fvalid <= 1'b0;
        v = 8'($urandom);
        wr(8'h30, v);
        rd(MSD_MODE_DIRECT, 8'h30, v);
        wr(8'h00, 8'h90);
        issue(1'b1, MSD_MODE_INDIRECT, 8'h00, ~v);
        rd(MSD_MODE_INDIRECT, 8'h00, ~v);
        rd(MSD_MODE_DIRECT, 8'h90, 8'h90 ^ 8'ha5);
        for (k = 0; k < 4; k++) begin
            wr(8'hd0, 8'(k << 3));
            v = 8'($urandom);
            issue(1'b1, MSD_MODE_REGISTER, 8'h00, v, 3'(k + 4));
            rd(MSD_MODE_DIRECT, 8'(9 * k + 4), v);
            issue(1'b1, MSD_MODE_REGISTER, 8'h00, 8'(8'h40 + k), 3'h1);
            issue(1'b1, MSD_MODE_INDIRECT, 8'h00, ~v, 3'h1);
            rd(MSD_MODE_DIRECT, 8'(8'h40 + k), ~v);
            idle();
            cmp_byte("bank", 8'(k), {6'h0, bank});
        end
        wr(8'hd0, 8'h00);
        for (k = 0; k < 3; k++) begin
            b = k == 0 ? 8'h00 : (k == 1 ? 8'h0b : 8'h7f);
            wr(8'h20 + b[6:3], 8'h00);
            issue(1'b1, MSD_MODE_BIT, b, 8'hff);
            rd(MSD_MODE_DIRECT, 8'h20 + b[6:3], 8'h01 << b[2:0]);
            rd(MSD_MODE_BIT, b, 8'h01, 1'b1);
            rd(MSD_MODE_BIT, b ^ 8'h01, 8'h00, 1'b1);
        end
        v = 8'hd0 ^ 8'ha5;
        rd(MSD_MODE_BIT, 8'hd4, {7'h0, v[4]}, 1'b1);
        issue(1'b1, MSD_MODE_BIT, 8'hd3, 8'hff);
        idle();
        cmp_byte("bank", 8'h01, {6'h0, bank});
        wr(8'hd0, 8'h00);
        v = 8'($urandom);
        issue(1'b1, MSD_MODE_PUSH, 8'h00, v);
        issue(1'b1, MSD_MODE_PUSH, 8'h00, ~v);
        rd(MSD_MODE_DIRECT, 8'h08, v);
        rd(MSD_MODE_POP, 8'h00, ~v);
        idle();
        cmp_byte("sp", 8'h08, sp);
        wr(8'h81, 8'hfe);
        wr(8'h00, 8'hff);
        issue(1'b1, MSD_MODE_PUSH, 8'h00, v ^ 8'h3c);
        rd(MSD_MODE_INDIRECT, 8'h00, v ^ 8'h3c);
        wr(8'h31, 8'h11);
        wr(8'h01, 8'h5c);
        for (k = 0; k < 8; k++) begin
            a = 16'($urandom);
            data_pointer_16 = a;
            page = a[15:8];
            exm(k == 5, k[0] ? MSD_MODE_EXT_REG : MSD_MODE_EXT_DATA_POINTER_16, 3'(k[1]),
                k[0] ? {a[15:8], k[1] ? 8'h5c : 8'hff} : a);
        end
        rd(MSD_MODE_DIRECT, 8'h31, 8'h11);
        idle();
        repeat (4) @(negedge i_clk);
        cmp_byte("pending", 8'h00, 8'(read_q.size() + ext_q.size() + fetch_q.size()));
        print_verdict();
    end
endmodule

`default_nettype wire
